// file: hdl/whs_pkg.sv
/*
  constants and types shared by the wake-up handshake sequencer.
  assumes a single 125 mhz system clock and no software register access.
*/
// What this block does
// - device registers the wake request and leaves sleep before acknowledging.
// - after the request registers, fault indicator goes low as acknowledge.
// - hardwired variant releases indicator and enters standby after init.
// - serial variant holds indicator low until clear-fault, then standby.
// - reset state held while motor-supply regulator is under voltage.
// - on regulator recovery, leave reset and run the acknowledge handshake.
// - logic supply under voltage also resets; recovery runs the handshake.
package whs_pkg;
  // clock rate and init interval
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned INIT_TIME_NS = 1000;
  localparam int unsigned INIT_CYCLES =
    (INIT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned INIT_CNT_W = 16;
  // reset values of pin outputs
  localparam logic FAULT_PIN_RST = 1'b1;
  // sequencer states
  typedef enum logic [2:0] {
    WHS_POR, WHS_SLEEP, WHS_WAKE, WHS_ACK, WHS_INIT, WHS_WAIT_CLR,
    WHS_STANDBY
  } whs_state_type;
endpackage

// file: hdl/whs_sync.sv
/*
  two-flop synchroniser for a single level.
  assumes the input is asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module whs_sync #(
  parameter logic RST_VAL_P = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_reg;
  logic sync_reg;
  // first flop feeds only the second; reset level chosen per instance
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= RST_VAL_P;
      sync_reg <= RST_VAL_P;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end
  assign sync_o = sync_reg;
endmodule

// file: hdl/whs_sequencer.sv
/*
  wake-up and power-up handshake sequencer of a half-bridge driver.
  assumes pins are asynchronous and synchronised here; clear-fault arrives
  as a one-cycle pulse from serial decode logic on the same clock.
*/
`timescale 1ns/1ps
module whs_sequencer #(
  parameter int unsigned INIT_CYCLES_P = whs_pkg::INIT_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic serial_variant_i,
  input wire logic sleep_request_pin_i,
  input wire logic motor_supply_uv_i,
  input wire logic logic_supply_uv_i,
  input wire logic clear_fault_command_i,
  output logic fault_indicator_pin_n_o,
  output logic fault_indicator_pin_oe_o,
  output logic standby_o,
  output logic sleep_o
);
  import whs_pkg::*;

  localparam logic [INIT_CNT_W-1:0] INIT_LAST =
    INIT_CNT_W'(INIT_CYCLES_P - 1);

  whs_state_type state_reg, state_next;
  logic [INIT_CNT_W-1:0] cnt_reg, cnt_next;
  logic fault_low_reg, fault_low_next;
  logic std_reg, std_next;
  logic slp_reg, slp_next;
  logic variant_reg;
  logic sleep_req, vm_uv, vdd_uv, variant_sync;

  // every pin input passes two flops before use; supply flags leave reset
  // showing undervoltage, so nothing starts before the supplies are seen good
  whs_sync #(.RST_VAL_P(1'b0)) u_sync_sleep (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .async_i(sleep_request_pin_i), .sync_o(sleep_req));
  whs_sync #(.RST_VAL_P(1'b1)) u_sync_vm (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .async_i(motor_supply_uv_i), .sync_o(vm_uv));
  whs_sync #(.RST_VAL_P(1'b1)) u_sync_vdd (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .async_i(logic_supply_uv_i), .sync_o(vdd_uv));
  // the variant strap is a pin as well
  whs_sync #(.RST_VAL_P(1'b0)) u_sync_var (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .async_i(serial_variant_i), .sync_o(variant_sync));

  // either supply low forces reset state
  wire por_hold = vm_uv | vdd_uv;
  wire init_done = (cnt_reg == INIT_LAST);
  // clear-fault only counts from the cycle after acknowledge goes out
  wire clr_ok = clear_fault_command_i &
    ((state_reg == WHS_INIT) || (state_reg == WHS_WAIT_CLR));

  // variant strap followed in the reset state, frozen once running
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) variant_reg <= 1'b0;
    else if (state_reg == WHS_POR) variant_reg <= variant_sync;
  end

  // next-state logic
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      WHS_POR: begin
        // recovery goes straight to acknowledge, no sleep needed
        if (!por_hold) state_next = WHS_ACK;
      end
      WHS_SLEEP: begin
        if (sleep_req) state_next = WHS_WAKE;
      end
      WHS_WAKE: state_next = WHS_ACK;
      WHS_ACK: begin
        cnt_next = '0;
        state_next = WHS_INIT;
      end
      WHS_INIT: begin
        cnt_next = cnt_reg + INIT_CNT_W'(1);
        if (init_done) begin
          // clear seen early still ends the wait at init end
          if (!variant_reg) state_next = WHS_STANDBY;
          else state_next = WHS_WAIT_CLR;
        end
      end
      WHS_WAIT_CLR: begin
        if (clr_ok) state_next = WHS_STANDBY;
      end
      WHS_STANDBY: begin
        if (!sleep_req) state_next = WHS_SLEEP;
      end
      default: state_next = WHS_POR;
    endcase
    if (por_hold) state_next = WHS_POR;
  end

  // early clear-fault during init is remembered
  logic early_clr_reg;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) early_clr_reg <= 1'b0;
    else if (state_reg == WHS_ACK) early_clr_reg <= 1'b0;
    else if (clr_ok && state_reg == WHS_INIT) early_clr_reg <= 1'b1;
  end
  // a clear taken on the last init cycle counts as early too
  wire skip_wait = state_reg == WHS_INIT && init_done &&
    (early_clr_reg || clr_ok);

  // output decode from next state
  wire [2:0] st_fix = (skip_wait && !por_hold) ? WHS_STANDBY : state_next;
  assign fault_low_next = (st_fix == WHS_INIT) || (st_fix == WHS_WAIT_CLR) ||
    (st_fix == WHS_ACK);
  assign std_next = (st_fix == WHS_STANDBY);
  assign slp_next = (st_fix == WHS_SLEEP) || (st_fix == WHS_POR);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= WHS_POR;
      cnt_reg <= '0;
      fault_low_reg <= 1'b0;
      std_reg <= 1'b0;
      slp_reg <= 1'b1;
    end else begin
      state_reg <= whs_state_type'(st_fix);
      cnt_reg <= cnt_next;
      fault_low_reg <= fault_low_next;
      std_reg <= std_next;
      slp_reg <= slp_next;
    end
  end

  // open-drain: drive low only while acknowledging
  assign fault_indicator_pin_n_o = ~FAULT_PIN_RST;
  assign fault_indicator_pin_oe_o = fault_low_reg;
  assign standby_o = std_reg;
  assign sleep_o = slp_reg;

  int unsigned ack_age;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) ack_age <= 0;
    else if (!fault_low_reg) ack_age <= 0;
    else ack_age <= ack_age + 1;
  end

  sequence s_wake_req;
    state_reg == WHS_SLEEP && sleep_req && !por_hold;
  endsequence
  sequence s_wake_ack;
    ##1 state_reg == WHS_WAKE ##1 state_reg == WHS_ACK && fault_low_reg;
  endsequence

  a_wake_then_ack: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) s_wake_req |-> s_wake_ack)
    else $error("wake request not followed by acknowledge");
  a_no_ack_in_sleep: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) state_reg == WHS_SLEEP |-> !fault_low_reg)
    else $error("indicator low while asleep");
  a_ack_low: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) state_reg == WHS_ACK |-> fault_indicator_pin_oe_o)
    else $error("acknowledge not driven low");
  a_hw_standby: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    state_reg == WHS_INIT && init_done && !variant_reg && !por_hold
    |=> standby_o && !fault_indicator_pin_oe_o)
    else $error("hardwired variant missed standby");
  a_serial_hold: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    state_reg == WHS_WAIT_CLR && !clear_fault_command_i && !por_hold
    |=> fault_indicator_pin_oe_o && !standby_o)
    else $error("indicator released without clear-fault");
  a_serial_clear: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    state_reg == WHS_WAIT_CLR && clear_fault_command_i && !por_hold
    |=> standby_o && !fault_indicator_pin_oe_o)
    else $error("clear-fault did not reach standby");
  a_por_hold: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) vm_uv |=> state_reg == WHS_POR)
    else $error("motor supply low but not in reset");
  a_por_leave: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) state_reg == WHS_POR && !por_hold
    |=> state_reg == WHS_ACK ##1 fault_low_reg)
    else $error("no handshake after supply recovery");
  a_vdd_hold: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) vdd_uv |=> state_reg == WHS_POR && !standby_o)
    else $error("logic supply low but not in reset");
  a_init_len: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !variant_reg && $rose(standby_o) |-> ack_age == INIT_CYCLES_P + 1 &&
    $past(ack_age) == INIT_CYCLES_P)
    else $error("init interval length wrong");
  a_clr_ignored: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) state_reg == WHS_SLEEP && clear_fault_command_i
    && !sleep_req && !por_hold |=> state_reg == WHS_SLEEP)
    else $error("clear-fault acted before acknowledge");

  // sleep is left no later than the acknowledge goes out
  a_sleep_left_first: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) $rose(fault_indicator_pin_oe_o) |-> !sleep_o)
    else $error("acknowledge given while still asleep");
  // reset state keeps every output quiet
  a_reset_quiet: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i) state_reg == WHS_POR
    |-> sleep_o && !standby_o && !fault_indicator_pin_oe_o)
    else $error("outputs active in reset state");
  // serial variant still waits at init end without a clear
  a_serial_wait: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    state_reg == WHS_INIT && init_done && variant_reg && !early_clr_reg &&
    !clear_fault_command_i && !por_hold
    |=> fault_indicator_pin_oe_o && !standby_o)
    else $error("serial variant released without clear-fault");
  // a clear taken during init ends the wait at init end
  a_early_clear: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    state_reg == WHS_INIT && init_done && !por_hold &&
    (early_clr_reg || clear_fault_command_i)
    |=> standby_o && !fault_indicator_pin_oe_o)
    else $error("clear-fault during init was lost");
  // standby holds while the pin stays high and supplies are good
  a_standby_held: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    state_reg == WHS_STANDBY && sleep_req && !por_hold
    |=> standby_o && !fault_indicator_pin_oe_o)
    else $error("standby left without cause");
endmodule

// file: tb/whs_ctrl_model.sv
/*
  controller model: drives the sleep-request pin and clear-fault pulse.
  assumes one clock shared with the sequencer; delay set by the bench.
*/
`timescale 1ns/1ps
module whs_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic wake_i,
  input wire logic serial_i,
  input wire logic [7:0] clr_delay_i,
  input wire logic fault_oe_i,
  output logic sleep_request_pin_o,
  output logic clear_fault_command_o
);
  logic [7:0] cnt_reg;
  logic sent_reg;
  // pin high requests wake-up
  assign sleep_request_pin_o = wake_i;
  // one clear per acknowledge, only after the indicator went low
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 8'h00;
      sent_reg <= 1'b0;
      clear_fault_command_o <= 1'b0;
    end else begin
      clear_fault_command_o <= 1'b0;
      if (!fault_oe_i) begin
        cnt_reg <= 8'h00;
        sent_reg <= 1'b0;
      end else if (serial_i && !sent_reg) begin
        if (cnt_reg == clr_delay_i) begin
          clear_fault_command_o <= 1'b1;
          sent_reg <= 1'b1;
        end else cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule

// file: tb/wakeup_handshake_sequencer_bench.sv
/*
  self-checking bench for the wake-up handshake sequencer.
  assumes a short init count and the controller model beside the dut.
*/
`timescale 1ns/1ps
module wakeup_handshake_sequencer_bench;
  localparam int INIT = 4;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic serial = 1'b0, wake = 1'b1, mv_uv = 1'b0, lv_uv = 1'b0;
  logic bclr = 1'b0, mclr, pin, oe, pin_n, standby, sleep;
  logic [7:0] dly = 8'h00;
  int miscompares = 0, checked = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  whs_ctrl_model ctrl (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .wake_i(wake), .serial_i(serial), .clr_delay_i(dly), .fault_oe_i(oe),
    .sleep_request_pin_o(pin), .clear_fault_command_o(mclr));
  whs_sequencer #(.INIT_CYCLES_P(INIT)) dut (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .serial_variant_i(serial),
    .sleep_request_pin_i(pin), .motor_supply_uv_i(mv_uv),
    .logic_supply_uv_i(lv_uv), .clear_fault_command_i(mclr | bclr),
    .fault_indicator_pin_n_o(pin_n), .fault_indicator_pin_oe_o(oe),
    .standby_o(standby), .sleep_o(sleep));
  task finish_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic c, input string m);
    checked++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // sample just after the edge so its updates have landed
  task tick(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task wait_oe(input logic v, output int n);
    n = 0;
    while (oe !== v && n < 300) begin
      tick(1);
      n++;
    end
  endtask
  // acknowledge, then standby after lo..hi cycles of indicator low
  task ack_standby(input int lo, input int hi);
    int n;
    wait_oe(1'b1, n);
    chk(n < 10 && sleep === 1'b0, "no acknowledge");
    chk(pin_n === 1'b0 && standby === 1'b0, "early standby");
    wait_oe(1'b0, n);
    chk(n >= lo && n <= hi, "ack length");
    chk(standby === 1'b1, "no standby");
  endtask
  task go_sleep;
    @(posedge clk_sys_i) wake <= 1'b0;
    tick(6);
    chk(sleep === 1'b1 && standby === 1'b0, "no sleep");
  endtask
  task hw_wake;
    go_sleep();
    @(posedge clk_sys_i) wake <= 1'b1;
    ack_standby(INIT, INIT + 3);
  endtask
  // undervoltage holds reset even with wake high, recovery reruns it
  task uv_cycle(input logic motor, input int lo, input int hi);
    @(posedge clk_sys_i) begin
      mv_uv <= motor;
      lv_uv <= !motor;
    end
    tick(20);
    chk(sleep === 1'b1 && oe === 1'b0 && standby === 1'b0, "uv");
    @(posedge clk_sys_i) begin
      mv_uv <= 1'b0;
      lv_uv <= 1'b0;
    end
    ack_standby(lo, hi);
  endtask
  // serial clear landing on the last init cycle still ends the wait there
  task late_init_clear;
    @(posedge clk_sys_i) dly <= 8'(INIT - 1);
    hw_wake();
  endtask
  // clear-fault while asleep must not shorten the next handshake
  task early_clear;
    go_sleep();
    @(posedge clk_sys_i) bclr <= 1'b1;
    @(posedge clk_sys_i) bclr <= 1'b0;
    tick(3);
    @(posedge clk_sys_i) wake <= 1'b1;
    ack_standby(60, 65);
  endtask
  initial begin
    tick(6);
    @(posedge clk_sys_i) arst_n_i <= 1'b1;
    ack_standby(INIT, INIT + 3);
    hw_wake();
    @(posedge clk_sys_i) begin
      serial <= 1'b1;
      dly <= 8'h3C;
    end
    uv_cycle(1'b1, 60, 65);
    @(posedge clk_sys_i) dly <= 8'h00;
    uv_cycle(1'b0, INIT, INIT + 3);
    late_init_clear();
    @(posedge clk_sys_i) dly <= 8'h3C;
    early_clear();
    finish_test();
  end
  // cut a hang well past the few hundred cycles the run needs
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule
